/* verilog/usart_control_status_regs.sv */
// Serial port with control, status, baud divisor and data-port registers
`timescale 1ns/1ps

// Behaviour
// R1: TX/RX-done flags raise interrupt when enabled
// R2: Low receive line in stop mode wakes
// R3: Transmitter and receiver run only when on; transmitter finishes a started frame after transmitter_on clears
// R4: Module enable gates the whole port; wake flag still set while disabled
// R5: Double speed halves async sampling factor
// R6: Role bit selects clock pin direction
// R7: Loopback bit routes transmit into receive
// R8: Clock gating bit limits clock to frames
// R9: SPI master drives slave select if enabled
// R10: One or two stop bits sent
// R11: Ninth transmit bit sent as MSB
// R12: Received ninth bit shown in field
// R13: Buffer empty flag resets one, write-zero clears
// R14: Done flag set when shifter idle, buffer empty
// R15: Receive flag held while unread data
// R16: Wake flag set only in async mode
// R17: Soft reset reinitialises port, self-clears
// R18: Overrun flag set, frames dropped until read
// R19: Framing error when first stop bit zero
// R20: Parity error flagged when checking enabled
// R21: Software never writes forbidden divisor values
// R22: Data address writes transmit, reads receive
// R23: Mode field: async 0, sync 1, SPI 3
// R24: Async rate is clock over 16(div+1)
module usart_control_status_regs (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       stop_mode,
    input  wire logic       rxd,
    output logic            txd,
    input  wire logic       serial_clock_pin_in,
    output logic            serial_clock_pin_out,
    output logic            serial_clock_pin_oe,
    output logic            slave_select_out,
    output logic            slave_select_oe,
    output logic            tx_irq,
    output logic            rx_irq,
    output logic            wake_irq
);

    // =========================================================
    // Registers
    logic [7:0]          ctrl1;
    usart_pkg::ctrl2_s   ctrl2;
    usart_pkg::ctrl3_s   ctrl3;
    logic [7:0]          baud_divisor;
    logic [7:0]          tx_buf;
    logic                tx_buf_full;
    logic                tx_buf_ninth;
    logic                tx_buffer_empty;
    logic                tx_done_flag;
    logic                wake_flag;
    logic                port_soft_reset;
    logic [7:0]          rx_buf;
    logic                rx_buf_ninth;
    logic                rx_data_available;
    logic                overrun_flag;
    logic                framing_error;
    logic                parity_error;
    logic [1:0]          rxd_sync;
    logic [2:0]          sck_sync;
    logic                port_rst;
    logic                mode_sel_async;
    logic                on;
    logic                wr_data;
    logic                rd_data;

    assign port_rst       = reset | port_soft_reset;                         // [R17]
    assign on             = ctrl2.port_clock_enable;                         // [R4]
    assign mode_sel_async = (usart_pkg::mode_e'(ctrl1[7:6]) == usart_pkg::mode_async); // [R23]
    assign wr_data        = wr & (addr == usart_pkg::data_addr);              // [R22]
    assign rd_data        = rd & (addr == usart_pkg::data_addr);              // [R22]

    // Pin synchronisers
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rxd_sync <= 2'b11;
            sck_sync <= 3'b000;
        end
        else
        begin
            rxd_sync <= {rxd_sync[0], rxd};
            sck_sync <= {sck_sync[1:0], serial_clock_pin_in};
        end
    end

    // =========================================================
    // Control registers
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ctrl1        <= usart_pkg::ctrl_reset;
            ctrl2        <= usart_pkg::ctrl2_s'(usart_pkg::ctrl_reset);
            ctrl3        <= usart_pkg::ctrl3_s'(usart_pkg::ctrl_reset);
            baud_divisor <= usart_pkg::baud_reset;
        end
        else if (wr)
        begin
            case (addr)
                usart_pkg::ctrl1_addr: ctrl1 <= wdata;
                usart_pkg::ctrl2_addr: ctrl2 <= usart_pkg::ctrl2_s'(wdata);
                usart_pkg::ctrl3_addr: ctrl3 <= usart_pkg::ctrl3_s'({wdata[7:4], 1'b0,
                                                wdata[2:1], ctrl3.rx_ninth_bit});
                usart_pkg::baud_addr:  baud_divisor <= wdata; // [R21]
                default: ;
            endcase
        end
    end

    // Soft reset pulse, clears itself next cycle
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            port_soft_reset <= 1'b0;
        else
            port_soft_reset <= wr & (addr == usart_pkg::status_addr)
                               & wdata[usart_pkg::st_srst];                  // [R17]
    end

    // =========================================================
    // Baud tick: one tick per sample, samples per bit 16 or 8
    logic [7:0] baud_cnt;
    logic       samp_tick;
    logic [4:0] over;
    logic [4:0] tx_samp;
    logic       bit_tick;
    assign over = (ctrl2.double_speed && mode_sel_async) ? usart_pkg::over_double
                                                         : usart_pkg::over_normal; // [R5] [R24]
    always_ff @(posedge ref_clk)
    begin
        if (port_rst || !on)
        begin
            baud_cnt  <= 8'h00;
            samp_tick <= 1'b0;
        end
        else
        begin
            samp_tick <= (baud_cnt == baud_divisor);                         // [R24]
            baud_cnt  <= (baud_cnt == baud_divisor) ? 8'h00 : baud_cnt + 8'h01;
        end
    end

    // Bit period counter; a clocked slave steps on the pin's rising edges
    assign bit_tick = (!mode_sel_async && !ctrl3.master) ? (sck_sync[1] & !sck_sync[2]) // [R6]
                                                         : (samp_tick & (tx_samp == over - 5'h01));
    always_ff @(posedge ref_clk)
    begin
        if (port_rst || !on)
            tx_samp <= 5'h00;
        else if (samp_tick)
            tx_samp <= (tx_samp == over - 5'h01) ? 5'h00 : tx_samp + 5'h01;
    end

    // =========================================================
    // Transmitter
    usart_pkg::tx_state_e tx_state;
    logic [8:0]           tx_shreg;
    logic [3:0]           tx_bits;
    logic [3:0]           frame_len;
    logic                 stop_left;
    assign frame_len = (ctrl1[3:1] == 3'b111) ? usart_pkg::size_nine
                                              : {2'b00, ctrl1[2:1]} + 4'h5;
    always_ff @(posedge ref_clk)
    begin
        if (port_rst || !on)
        begin
            tx_state  <= usart_pkg::tx_idle;
            tx_shreg  <= 9'h1ff;
            tx_bits   <= 4'h0;
            stop_left <= 1'b0;
            txd       <= 1'b1;
        end
        else if (bit_tick)
        begin
            case (tx_state)
                usart_pkg::tx_idle:
                    if (tx_buf_full && ctrl2.transmitter_on)                 // [R3]
                    begin
                        tx_shreg <= {tx_buf_ninth, tx_buf};                  // [R11]
                        tx_bits  <= 4'h0;
                        txd      <= 1'b0;
                        tx_state <= usart_pkg::tx_shift;
                    end
                usart_pkg::tx_shift:
                begin
                    txd      <= tx_shreg[0] | (tx_bits == frame_len);
                    tx_shreg <= {1'b1, tx_shreg[8:1]};
                    tx_bits  <= tx_bits + 4'h1;
                    if (tx_bits == frame_len)
                    begin
                        tx_state  <= usart_pkg::tx_stop;
                        stop_left <= ctrl3.two_stop_bits;                    // [R10]
                    end
                end
                usart_pkg::tx_stop:
                begin
                    txd <= 1'b1;
                    if (stop_left)
                        stop_left <= 1'b0;                                   // [R10]
                    else
                        tx_state <= usart_pkg::tx_idle;
                end
                default: tx_state <= usart_pkg::tx_idle;
            endcase
        end
    end

    // Transmit buffer and flags
    logic tx_load;
    logic tx_finish;
    assign tx_load   = bit_tick & (tx_state == usart_pkg::tx_idle) & tx_buf_full
                       & ctrl2.transmitter_on;
    assign tx_finish = bit_tick & (tx_state == usart_pkg::tx_stop) & !stop_left;
    always_ff @(posedge ref_clk)
    begin
        if (port_rst)
        begin
            tx_buf          <= usart_pkg::data_reset;
            tx_buf_full     <= 1'b0;
            tx_buf_ninth    <= 1'b0;
            tx_buffer_empty <= 1'b1;                                         // [R13]
            tx_done_flag    <= 1'b0;
        end
        else
        begin
            if (wr_data)
            begin
                tx_buf       <= wdata;                                       // [R22]
                tx_buf_ninth <= ctrl3.tx_ninth_bit;                          // [R11]
                tx_buf_full  <= 1'b1;
            end
            else if (tx_load)
                tx_buf_full <= 1'b0;
            // Hardware set wins over software clear
            if (tx_load)
                tx_buffer_empty <= 1'b1;                                     // [R13]
            else if (wr_data || (wr && addr == usart_pkg::status_addr
                                 && !wdata[usart_pkg::st_empty]))
                tx_buffer_empty <= 1'b0;                                     // [R13]
            if (tx_finish && !tx_buf_full)
                tx_done_flag <= 1'b1;                                        // [R14]
            else if (wr && addr == usart_pkg::status_addr && !wdata[usart_pkg::st_txc])
                tx_done_flag <= 1'b0;                                        // [R14]
        end
    end

    // =========================================================
    // Receiver: samples counted from start edge, bit value at mid-point
    logic       rx_in;
    logic       rx_busy;
    logic [4:0] rx_samp;
    logic [3:0] rx_bits;
    logic [8:0] rx_shreg;
    logic       rx_par;
    logic       rx_done;
    assign rx_in = ctrl3.loopback_en ? txd : rxd_sync[1];                   // [R7]
    always_ff @(posedge ref_clk)
    begin
        if (port_rst || !on || !ctrl2.receiver_on)                           // [R3]
        begin
            rx_busy  <= 1'b0;
            rx_samp  <= 5'h00;
            rx_bits  <= 4'h0;
            rx_shreg <= 9'h000;
            rx_par   <= 1'b0;
            rx_done  <= 1'b0;
        end
        else
        begin
            rx_done <= 1'b0;
            if (!rx_busy)
            begin
                if (!rx_in)
                begin
                    rx_busy <= 1'b1;
                    rx_samp <= 5'h00;
                    rx_bits <= 4'h0;
                    rx_par  <= ctrl1[4];
                end
            end
            else if (samp_tick)
            begin
                rx_samp <= (rx_samp == over - 5'h01) ? 5'h00 : rx_samp + 5'h01;
                if (rx_samp == (over >> 1))
                begin
                    rx_bits <= rx_bits + 4'h1;
                    if (rx_bits == 4'h0 && rx_in)
                        rx_busy <= 1'b0;
                    else if (rx_bits != 4'h0 && rx_bits <= frame_len)
                    begin
                        rx_shreg <= {rx_in, rx_shreg[8:1]};
                        rx_par   <= rx_par ^ rx_in;
                    end
                    else if (rx_bits > frame_len)
                    begin
                        rx_busy <= 1'b0;
                        rx_done <= 1'b1;
                    end
                end
            end
        end
    end

    // Receive buffer and error flags
    logic [8:0] rx_aligned;
    logic       stop_ok;
    assign rx_aligned = rx_shreg >> (4'h9 - frame_len);
    assign stop_ok    = rx_in;
    always_ff @(posedge ref_clk)
    begin
        if (port_rst)
        begin
            rx_buf            <= usart_pkg::data_reset;
            rx_buf_ninth      <= 1'b0;
            rx_data_available <= 1'b0;
            overrun_flag      <= 1'b0;
            framing_error     <= 1'b0;
            parity_error      <= 1'b0;
        end
        else if (rx_done && rx_data_available)
            overrun_flag <= 1'b1;                                            // [R18]
        else if (rx_done && !overrun_flag)
        begin
            rx_buf            <= rx_aligned[7:0];
            rx_buf_ninth      <= rx_aligned[8];                              // [R12]
            rx_data_available <= 1'b1;                                       // [R15]
            framing_error     <= !stop_ok;                                   // [R19]
            parity_error      <= ctrl1[5] & rx_par;                          // [R20]
        end
        else if (rd_data)
        begin
            rx_data_available <= 1'b0;                                       // [R15]
            overrun_flag      <= 1'b0;                                       // [R18]
            framing_error     <= 1'b0;
            parity_error      <= 1'b0;
        end
    end

    // Wake flag, set wins over clear
    always_ff @(posedge ref_clk)
    begin
        if (port_rst)
            wake_flag <= 1'b0;
        else if (stop_mode && mode_sel_async && !rxd_sync[1])
            wake_flag <= 1'b1;                                               // [R16]
        else if (wr && addr == usart_pkg::status_addr && !wdata[usart_pkg::st_wake])
            wake_flag <= 1'b0;
    end

    // =========================================================
    // Clock and select pins in synchronous and SPI modes
    logic sync_mode;
    logic frame_active;
    assign sync_mode    = on && !mode_sel_async && ctrl3.master;             // [R6]
    assign frame_active = (tx_state != usart_pkg::tx_idle);
    always_ff @(posedge ref_clk)
    begin
        if (port_rst)
        begin
            serial_clock_pin_out <= 1'b0;
            serial_clock_pin_oe  <= 1'b0;
            slave_select_out     <= 1'b1;
            slave_select_oe      <= 1'b0;
        end
        else
        begin
            serial_clock_pin_oe <= sync_mode;                                // [R6]
            if (sync_mode && (!ctrl3.clock_gate_to_frame || frame_active))   // [R8]
                serial_clock_pin_out <= (tx_samp >= (over >> 1));
            else
                serial_clock_pin_out <= ctrl1[0];
            slave_select_oe  <= sync_mode && ctrl3.slave_select_output_en
                                && (usart_pkg::mode_e'(ctrl1[7:6]) == usart_pkg::mode_spi); // [R9]
            slave_select_out <= !frame_active;
        end
    end

    // =========================================================
    // Interrupt requests and read data
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            tx_irq   <= 1'b0;
            rx_irq   <= 1'b0;
            wake_irq <= 1'b0;
            rdata    <= 8'h00;
        end
        else
        begin
            tx_irq   <= ctrl2.tx_done_irq_en & tx_done_flag;                 // [R1]
            rx_irq   <= ctrl2.rx_done_irq_en & rx_data_available;            // [R1]
            wake_irq <= ctrl2.stop_wakeup_irq_en & wake_flag & stop_mode;    // [R2]
            if (rd)
            begin
                case (addr)
                    usart_pkg::ctrl1_addr:  rdata <= ctrl1;
                    usart_pkg::ctrl2_addr:  rdata <= ctrl2;
                    usart_pkg::ctrl3_addr:  rdata <= {ctrl3[7:1], rx_buf_ninth}; // [R12]
                    usart_pkg::status_addr: rdata <= {tx_buffer_empty, tx_done_flag,
                                                      rx_data_available, wake_flag, 1'b0,
                                                      overrun_flag, framing_error, parity_error};
                    usart_pkg::baud_addr:   rdata <= baud_divisor;
                    usart_pkg::data_addr:   rdata <= rx_buf;                 // [R22]
                    default:                rdata <= 8'h00;
                endcase
            end
            else
                rdata <= 8'h00;
        end
    end

    // =========================================================
    // Assertions
    tx_irq_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
        tx_irq |-> $past(ctrl2.tx_done_irq_en && tx_done_flag))              // [R1]
        else $error("tx irq without enabled flag");
    wake_async_a: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(wake_flag) |-> $past(mode_sel_async && stop_mode))             // [R16]
        else $error("wake flag set outside async stop");
    srst_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
        port_soft_reset |=> !port_soft_reset && tx_buffer_empty)             // [R17]
        else $error("soft reset not self clearing");
    empty_set_a: assert property (@(posedge ref_clk) disable iff (reset)
        tx_load |=> tx_buffer_empty)                                         // [R13]
        else $error("buffer empty not set on load");
    rx_avail_a: assert property (@(posedge ref_clk) disable iff (reset || port_soft_reset)
        rd_data && !rx_done |=> !rx_data_available)                          // [R15]
        else $error("receive flag not cleared on read");
    clk_dir_a: assert property (@(posedge ref_clk) disable iff (reset)
        serial_clock_pin_oe |-> $past(ctrl3.master))                         // [R6]
        else $error("clock driven as slave");
    ss_out_a: assert property (@(posedge ref_clk) disable iff (reset)
        slave_select_oe |-> $past(ctrl3.slave_select_output_en))             // [R9]
        else $error("select driven without enable");
    overrun_a: assert property (@(posedge ref_clk) disable iff (reset || port_soft_reset)
        rx_done && rx_data_available && !rd_data |=> overrun_flag && $stable(rx_buf)) // [R18]
        else $error("overrun not flagged");
    txd_off_a: assert property (@(posedge ref_clk) disable iff (reset)
        !on |=> txd)                                                         // [R4]
        else $error("line active while port disabled");
    cov_tx_c:   cover property (@(posedge ref_clk) tx_finish);
    cov_rx_c:   cover property (@(posedge ref_clk) rx_done);
    cov_ovr_c:  cover property (@(posedge ref_clk) $rose(overrun_flag));
    cov_wake_c: cover property (@(posedge ref_clk) $rose(wake_irq));

endmodule : usart_control_status_regs

/* verilog/usart_pkg.sv */
// Package: register map, field positions, reset values and modes of the serial port
package usart_pkg;

    // =========================================================
    // Register offsets
    localparam logic [7:0] ctrl1_addr   = 8'hfa;
    localparam logic [7:0] ctrl2_addr   = 8'hfb;
    localparam logic [7:0] ctrl3_addr   = 8'hfc;
    localparam logic [7:0] status_addr  = 8'hfd;
    localparam logic [7:0] baud_addr    = 8'hfe;
    localparam logic [7:0] data_addr    = 8'hff;

    // =========================================================
    // Reset values
    localparam logic [7:0] ctrl_reset   = 8'h00;
    localparam logic [7:0] status_reset = 8'h80;
    localparam logic [7:0] baud_reset   = 8'hff;
    localparam logic [7:0] data_reset   = 8'hff;

    // =========================================================
    // Status bit positions
    localparam int st_empty = 7;
    localparam int st_txc   = 6;
    localparam int st_rxc   = 5;
    localparam int st_wake  = 4;
    localparam int st_srst  = 3;

    // =========================================================
    // Sampling rates and nine-bit frame length
    localparam logic [4:0] over_normal = 5'h10;
    localparam logic [4:0] over_double = 5'h08;
    localparam logic [3:0] size_nine   = 4'h9;

    // =========================================================
    // Operating modes
    typedef enum logic [1:0] {
        mode_async = 2'b00,
        mode_sync  = 2'b01,
        mode_rsvd  = 2'b10,
        mode_spi   = 2'b11
    } mode_e;

    // Control group 2
    typedef struct packed {
        logic buf_empty_irq_en;
        logic tx_done_irq_en;
        logic rx_done_irq_en;
        logic stop_wakeup_irq_en;
        logic transmitter_on;
        logic receiver_on;
        logic port_clock_enable;
        logic double_speed;
    } ctrl2_s;

    // Control group 3
    typedef struct packed {
        logic master;
        logic loopback_en;
        logic clock_gate_to_frame;
        logic slave_select_output_en;
        logic unused;
        logic two_stop_bits;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
    } ctrl3_s;

    // Transmitter states
    typedef enum logic [1:0] {
        tx_idle  = 2'b00,
        tx_shift = 2'b01,
        tx_stop  = 2'b10
    } tx_state_e;

endpackage : usart_pkg

/* bench/remote_uart.sv */
// Remote serial peer: drives the receive line, captures transmit frames, bursts the link clock
`timescale 1ns/1ps
module remote_uart #(
    parameter int bit_clks = 32
) (
    input  wire logic ref_clk,
    input  wire logic txd,
    output logic      rxd,
    output logic      link_clk
);
    initial rxd = 1'b1;
    initial link_clk = 1'b0;
    // One frame, LSB first, chosen stop level, then an idle bit
    task automatic send(input logic [7:0] d, input logic stop);
        repeat (bit_clks) @(posedge ref_clk) rxd <= 1'b0;
        for (int i = 0; i < 8; i++)
            repeat (bit_clks) @(posedge ref_clk) rxd <= d[i];
        repeat (bit_clks) @(posedge ref_clk) rxd <= stop;
        repeat (bit_clks) @(posedge ref_clk) rxd <= 1'b1;
    endtask : send
    // Mid-bit sampling of a frame; returns at the middle of the first stop bit
    task automatic grab(output logic [7:0] d);
        int n;
        n = 0;
        while (txd !== 1'b0 && n < 4000)
        begin
            @(posedge ref_clk);
            n++;
        end
        repeat (bit_clks / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (bit_clks) @(posedge ref_clk);
            d[i] = txd;
        end
        repeat (bit_clks) @(posedge ref_clk);
    endtask : grab
    // Link clock runs only inside a burst, 160 ns period
    task automatic burst();
        repeat (16) #80 link_clk = ~link_clk;
    endtask : burst
endmodule : remote_uart

/* bench/testbench.sv */
// Self-checking bench for the serial port registers and line
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 0, reset = 1, wr = 0, rd = 0, stop_mode = 0;
    logic [7:0] addr = 0, wdata = 0, rdata, d;
    logic rxd, txd, sck, sck_o, sck_oe, ss_o, ss_oe, tx_irq, rx_irq, wake_irq;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    usart_control_status_regs i_dut (.ref_clk(ref_clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stop_mode(stop_mode), .rxd(rxd),
        .txd(txd), .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_o),
        .serial_clock_pin_oe(sck_oe), .slave_select_out(ss_o), .slave_select_oe(ss_oe),
        .tx_irq(tx_irq), .rx_irq(rx_irq), .wake_irq(wake_irq));
    remote_uart i_peer (.ref_clk(ref_clk), .txd(txd), .rxd(rxd), .link_clk(sck));
    initial forever #10 ref_clk = ~ref_clk;
    // ==========================================================
    // Bus and compare helpers
    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rchk
    // Line must stay idle high for a while
    task automatic quiet();
        repeat (400) @(posedge ref_clk) if (txd !== 1'b1) chk(8'h00, 8'h01);
        chk({7'h0, txd}, 8'h01);
    endtask : quiet
    // ==========================================================
    // Scenarios
    task automatic t_tx(input logic two);
        wreg(usart_pkg::ctrl3_addr, two ? 8'h04 : 8'h00);
        wreg(usart_pkg::baud_addr, 8'h01);
        wreg(usart_pkg::ctrl2_addr, 8'h6e);
        wreg(usart_pkg::data_addr, 8'ha5);
        i_peer.grab(d);
        chk(d, 8'ha5);
        repeat (32) @(posedge ref_clk);
        chk({7'h0, tx_irq}, {7'h0, !two});
        repeat (40) @(posedge ref_clk);
        wreg(usart_pkg::status_addr, 8'hb0);
        repeat (2) @(posedge ref_clk);
        chk({7'h0, tx_irq}, 8'h00);
        $display("tx test done");
    endtask : t_tx
    task automatic t_rx();
        i_peer.send(8'h3c, 1'b1);
        chk({7'h0, rx_irq}, 8'h01);
        rchk(usart_pkg::status_addr, 8'ha0);
        rchk(usart_pkg::data_addr, 8'h3c);
        rchk(usart_pkg::status_addr, 8'h80);
        i_peer.send(8'h5a, 1'b0);
        rchk(usart_pkg::status_addr, 8'ha2);
        rchk(usart_pkg::data_addr, 8'h5a);
        i_peer.send(8'h11, 1'b1);
        i_peer.send(8'h22, 1'b1);
        rchk(usart_pkg::status_addr, 8'ha4);
        rchk(usart_pkg::data_addr, 8'h11);
        rchk(usart_pkg::status_addr, 8'h80);
        wreg(usart_pkg::ctrl1_addr, 8'h0e);
        wreg(usart_pkg::ctrl3_addr, 8'h42);
        wreg(usart_pkg::data_addr, 8'h96);
        repeat (450) @(posedge ref_clk);
        rchk(usart_pkg::ctrl3_addr, 8'h43);
        rchk(usart_pkg::data_addr, 8'h96);
        wreg(usart_pkg::ctrl3_addr, 8'h00);
        $display("rx test done");
    endtask : t_rx
    task automatic t_role();
        wreg(usart_pkg::baud_addr, 8'h02);
        wreg(usart_pkg::ctrl1_addr, 8'h46);
        wreg(usart_pkg::ctrl3_addr, 8'h80);
        repeat (3) @(posedge ref_clk);
        chk({7'h0, sck_oe}, 8'h01);
        wreg(usart_pkg::ctrl3_addr, 8'h00);
        wreg(usart_pkg::data_addr, 8'h00);
        quiet();
        i_peer.burst();
        chk({7'h0, sck_oe}, 8'h00);
        chk({7'h0, txd}, 8'h00);
        wreg(usart_pkg::ctrl1_addr, 8'hc6);
        wreg(usart_pkg::ctrl3_addr, 8'h90);
        repeat (3) @(posedge ref_clk);
        chk({7'h0, ss_oe}, 8'h01);
        wreg(usart_pkg::ctrl3_addr, 8'h80);
        repeat (3) @(posedge ref_clk);
        chk({7'h0, ss_oe}, 8'h00);
        wreg(usart_pkg::ctrl1_addr, 8'h06);
        wreg(usart_pkg::ctrl3_addr, 8'h00);
        wreg(usart_pkg::baud_addr, 8'h01);
        $display("role test done");
    endtask : t_role
    task automatic t_wake();
        wreg(usart_pkg::ctrl2_addr, 8'h16);
        stop_mode <= 1'b1;
        i_peer.send(8'h00, 1'b1);
        chk({7'h0, wake_irq}, 8'h01);
        rchk(usart_pkg::status_addr, 8'hf0);
        wreg(usart_pkg::status_addr, 8'ha0);
        stop_mode <= 1'b0;
        rchk(usart_pkg::status_addr, 8'ha0);
        rchk(usart_pkg::data_addr, 8'h00);
        $display("wake test done");
    endtask : t_wake
    // ==========================================================
    // Main sequence and run control
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            conclude();
        end
    end
    initial
    begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        rchk(usart_pkg::status_addr, 8'h80);
        rchk(usart_pkg::baud_addr, 8'hff);
        rchk(usart_pkg::data_addr, 8'hff);
        rchk(8'h10, 8'h00);
        wreg(usart_pkg::ctrl1_addr, 8'h06);
        t_tx(1'b0);
        t_tx(1'b1);
        wreg(usart_pkg::ctrl2_addr, 8'h06);
        wreg(usart_pkg::data_addr, 8'h55);
        quiet();
        wreg(usart_pkg::ctrl2_addr, 8'h08);
        quiet();
        wreg(usart_pkg::status_addr, 8'h08);
        rchk(usart_pkg::status_addr, 8'h80);
        wreg(usart_pkg::ctrl2_addr, 8'h6e);
        t_rx();
        t_role();
        t_wake();
        conclude();
    end
endmodule : testbench
